// ==== sfp_defs.svh ====
// shared constants for the serial flash program, erase and lock sequencer
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH
`define SFP_CLK_PERIOD_NS           10
`define SFP_PROGRAM_CYCLE_TIME_NS   20000
`define SFP_PAGE_ERASE_TIME_NS      20000
`define SFP_SUBSECTOR_ERASE_TIME_NS 100000
`define SFP_WRITE_ENABLE_CMD_BYTES              3'h1
`define SFP_HDR_BYTES               3'h4
`define SFP_LOCK_BYTES              3'h5
`define SFP_CNT_SAT                 3'h6
`define SFP_LOCK_WR_BIT             0
`define SFP_LOCK_DOWN_BIT           1
`define SFP_LOCK_RESET              2'h0
`define SFP_ERASED_BYTE             8'hff
`define SFP_PAGE_LAST               12'h0ff
`define SFP_SUB_LAST                12'hfff
`endif

// ==== sfp_pkg.sv ====
// types shared by the serial flash program, erase and lock sequencer
package sfp_pkg;
  typedef enum logic [2:0] {
    SFP_IDLE  = 3'h0,
    SFP_P_RD  = 3'h1,
    SFP_P_WT  = 3'h3,
    SFP_P_WR  = 3'h2,
    SFP_ERASE = 3'h6,
    SFP_HOLD  = 3'h7
  } sfp_state_e;
  typedef enum logic [1:0] {
    SFP_K_PROG = 2'h0,
    SFP_K_PE   = 2'h1,
    SFP_K_SSE  = 2'h2
  } sfp_kind_e;
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [18:0] addr;
    logic [7:0]  data;
  } sfp_arr_s;
  typedef struct packed {
    logic sel_n;
    logic sck;
    logic din;
  } sfp_spi_s;
endpackage

// ==== sfp_flash_seq.sv ====
// serial flash command sequencer: page program, lock byte write, page and subsector erase
// Function
// - page program only clears bits from one to zero, never sets them
// - these instructions need the write enable latch set by a prior write enable
// - the five top address bits are ignored
// - data past the page end wraps to offset zero of the same page
// - over 256 bytes keeps the last 256; fewer bytes touch only their addresses
// - select must rise right after a complete data byte or nothing programs
// - valid program starts a timed cycle with write in progress high throughout
// - write enable latch clears during every timed program or erase cycle
// - program or page erase on a hardware protected page is not executed
// - these instructions are rejected while a cycle runs, leaving it untouched
// - lock write is opcode, three address bytes, one data byte, exact end
// - lock bits are volatile, untimed; latch clears within the select high time
// - lock data bit 1 is lock down, bit 0 write lock, others zero
// - page erase sets the addressed page to all ones over the page erase time
// - erases need select to rise right after the third address byte
// - subsector erase sets the subsector to ones with write in progress set
// - subsector erase refused if any page is hardware or software protected
// - reset aborts a running subsector erase; host waits before reselecting
// - lock write and subsector erase exist only in one device variant
// - sectors with write lock set are not written, programmed or erased
// - once lock down is set the sector lock bits are frozen until reset
`timescale 1ns/1ps
`include "sfp_defs.svh"
module sfp_flash_seq #(
  parameter logic [7:0] OP_WRITE_ENABLE_CMD      = 8'h31,
  parameter logic [7:0] OP_PP        = 8'h32,
  parameter logic [7:0] OP_LOCK      = 8'h33,
  parameter logic [7:0] OP_PE        = 8'h34,
  parameter logic [7:0] OP_SSE       = 8'h35,
  parameter bit         HAS_LOCK_SSE = 1'b1,
  parameter int unsigned PP_CYCLES   =
    (`SFP_PROGRAM_CYCLE_TIME_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS,
  parameter int unsigned PE_CYCLES   =
    (`SFP_PAGE_ERASE_TIME_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS,
  parameter int unsigned SSE_CYCLES  =
    (`SFP_SUBSECTOR_ERASE_TIME_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  // serial pins, synchronous levels
  input  wire sfp_pkg::sfp_spi_s i_spi,
  // hardware protection: pages at or above the index are protected when enabled
  input  wire logic              i_hw_prot_en,
  input  wire logic [10:0]       i_hw_prot_page,
  // array port: read data is valid the cycle after o_arr.rd
  input  wire logic [7:0]        i_arr_rdata,
  output sfp_pkg::sfp_arr_s      o_arr,
  // status
  output logic                   o_wip,
  output logic                   o_wel
);

  logic                 sel_q;
  logic                 sck_q;
  logic [2:0]           bit_cnt;
  logic [2:0]           byte_cnt;
  logic [7:0]           shreg;
  logic [7:0]           opcode;
  logic [18:0]          addr;
  logic [7:0]           wptr;
  logic                 seq_rej;
  logic [7:0]           page_buf [256];
  logic [255:0]         page_vld;
  logic [1:0]           lock [8];
  logic [7:0]           down_vec;
  sfp_pkg::sfp_state_e  state;
  sfp_pkg::sfp_kind_e   kind;
  logic [18:0]          base;
  logic [11:0]          idx;
  logic [23:0]          timer;
  logic                 sck_rise;
  logic                 sel_rise;
  logic                 byte_done;
  logic [7:0]           byte_in;
  logic                 ok_base;
  logic                 hw_page;
  logic                 hw_sub;
  logic                 wlock;
  logic                 buf_we;
  logic                 go_write_enable_cmd;
  logic                 go_pp;
  logic                 go_pe;
  logic                 go_sse;
  logic                 go_lock;
  logic                 start;

  // edge detection on the serial pins
  assign sck_rise  = i_spi.sck & ~sck_q & ~i_spi.sel_n;
  assign sel_rise  = i_spi.sel_n & ~sel_q;
  assign byte_in   = {shreg[6:0], i_spi.din};
  assign byte_done = sck_rise & (bit_cnt == 3'h7);

  // previous pin levels
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sel_q <= 1'b1;
      sck_q <= 1'b0;
    end else begin
      sel_q <= i_spi.sel_n;
      sck_q <= i_spi.sck;
    end
  end

  // bit and byte counters, restarted whenever select is high
  always_ff @(posedge i_clk) begin
    if (!i_resetn || i_spi.sel_n) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
      shreg    <= 8'h00;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      shreg   <= byte_in;
      // saturating: only short counts matter for framing
      if (bit_cnt == 3'h7 && byte_cnt != `SFP_CNT_SAT) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
    end
  end

  // opcode and address capture
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      opcode <= 8'h00;
      addr   <= 19'h00000;
    end else if (byte_done) begin
      unique case (byte_cnt)
        3'h0: opcode <= byte_in;
        3'h1: addr[18:16] <= byte_in[2:0]; // top five bits dropped
        3'h2: addr[15:8] <= byte_in;
        3'h3: addr[7:0] <= byte_in;
        default: ;
      endcase
    end
  end

  // a sequence that saw a running cycle can never start one
  always_ff @(posedge i_clk) begin
    if (!i_resetn || i_spi.sel_n) begin
      seq_rej <= 1'b0;
    end else if (o_wip) begin
      seq_rej <= 1'b1;
    end
  end

  // page buffer: frozen while a cycle runs so it cannot be corrupted
  assign buf_we = byte_done & (byte_cnt >= `SFP_HDR_BYTES) & (opcode == OP_PP) & ~o_wip;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wptr <= 8'h00;
    end else if (byte_done && byte_cnt == 3'h3) begin
      wptr <= byte_in;
    end else if (buf_we) begin
      wptr <= wptr + 8'h01; // wraps inside the page
    end
  end

  always_ff @(posedge i_clk) begin
    if (buf_we) begin
      page_buf[wptr] <= byte_in; // later bytes overwrite earlier ones
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      page_vld <= '0;
    end else if (!o_wip && !i_spi.sel_n && sel_q) begin
      page_vld <= '0;
    end else if (buf_we) begin
      page_vld[wptr] <= 1'b1; // unsent offsets stay untouched
    end
  end

  // protection lookups
  assign hw_page = i_hw_prot_en & (addr[18:8] >= i_hw_prot_page);
  assign hw_sub  = i_hw_prot_en & ({addr[18:12], 4'hf} >= i_hw_prot_page);
  assign wlock   = lock[addr[18:16]][`SFP_LOCK_WR_BIT];

  // decode at the rising select edge; framing must end on a byte boundary
  assign ok_base = sel_rise & (bit_cnt == 3'h0) & ~o_wip & ~seq_rej;
  assign go_write_enable_cmd = ok_base & (opcode == OP_WRITE_ENABLE_CMD) & (byte_cnt == `SFP_WRITE_ENABLE_CMD_BYTES);
  assign go_pp   = ok_base & o_wel & (opcode == OP_PP) & (byte_cnt >= `SFP_LOCK_BYTES)
                 & ~hw_page & ~wlock;
  assign go_pe   = ok_base & o_wel & (opcode == OP_PE) & (byte_cnt == `SFP_HDR_BYTES)
                 & ~hw_page & ~wlock;
  assign go_sse  = ok_base & o_wel & HAS_LOCK_SSE & (opcode == OP_SSE)
                 & (byte_cnt == `SFP_HDR_BYTES) & ~hw_sub & ~wlock;
  assign go_lock = ok_base & o_wel & HAS_LOCK_SSE & (opcode == OP_LOCK)
                 & (byte_cnt == `SFP_LOCK_BYTES);
  assign start   = go_pp | go_pe | go_sse;

  // volatile per-sector lock bytes; only bits 1 and 0 are stored
  generate
    for (genvar s = 0; s < 8; s++) begin : g_lock
      assign down_vec[s] = lock[s][`SFP_LOCK_DOWN_BIT];
      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          lock[s] <= `SFP_LOCK_RESET;
        end else if (go_lock && addr[18:16] == 3'(s) && !lock[s][`SFP_LOCK_DOWN_BIT]) begin
          lock[s] <= shreg[1:0];
        end
      end
    end
  endgenerate

  // write enable latch, cleared as a timed cycle starts or after a lock write
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_wel <= 1'b0;
    end else if (go_write_enable_cmd) begin
      o_wel <= 1'b1;
    end else if (go_lock || start) begin
      o_wel <= 1'b0;
    end
  end

  // self-timed cycle: array work first, then hold until the timer expires
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state <= sfp_pkg::SFP_IDLE; // reset aborts any cycle
      kind  <= sfp_pkg::SFP_K_PROG;
      o_wip <= 1'b0;
      o_arr <= '0;
      base  <= 19'h00000;
      idx   <= 12'h000;
      timer <= 24'h000000;
    end else begin
      o_arr.rd <= 1'b0;
      o_arr.wr <= 1'b0;
      if (o_wip && timer != 24'h000000) begin
        timer <= timer - 24'h000001;
      end
      unique case (state)
        sfp_pkg::SFP_IDLE: begin
          if (start) begin
            o_wip <= 1'b1;
            idx   <= 12'h000;
            if (go_pp) begin
              kind  <= sfp_pkg::SFP_K_PROG;
              base  <= {addr[18:8], 8'h00};
              timer <= 24'(PP_CYCLES - 1);
              state <= sfp_pkg::SFP_P_RD;
            end else if (go_pe) begin
              kind  <= sfp_pkg::SFP_K_PE;
              base  <= {addr[18:8], 8'h00};
              timer <= 24'(PE_CYCLES - 1);
              state <= sfp_pkg::SFP_ERASE;
            end else begin
              kind  <= sfp_pkg::SFP_K_SSE;
              base  <= {addr[18:12], 12'h000};
              timer <= 24'(SSE_CYCLES - 1);
              state <= sfp_pkg::SFP_ERASE;
            end
          end
        end
        sfp_pkg::SFP_P_RD: begin
          if (page_vld[idx[7:0]]) begin
            o_arr.rd   <= 1'b1;
            o_arr.addr <= {base[18:8], idx[7:0]};
            state      <= sfp_pkg::SFP_P_WT;
          end else if (idx == `SFP_PAGE_LAST) begin
            state <= sfp_pkg::SFP_HOLD;
          end else begin
            idx <= idx + 12'h001;
          end
        end
        sfp_pkg::SFP_P_WT: state <= sfp_pkg::SFP_P_WR;
        sfp_pkg::SFP_P_WR: begin
          o_arr.wr   <= 1'b1;
          o_arr.data <= i_arr_rdata & page_buf[idx[7:0]];
          idx        <= idx + 12'h001;
          state      <= (idx == `SFP_PAGE_LAST) ? sfp_pkg::SFP_HOLD : sfp_pkg::SFP_P_RD;
        end
        sfp_pkg::SFP_ERASE: begin
          o_arr.wr   <= 1'b1;
          o_arr.addr <= {base[18:12], base[11:0] | idx};
          o_arr.data <= `SFP_ERASED_BYTE;
          idx        <= idx + 12'h001;
          if (idx == ((kind == sfp_pkg::SFP_K_PE) ? `SFP_PAGE_LAST : `SFP_SUB_LAST)) begin
            state <= sfp_pkg::SFP_HOLD;
          end
        end
        sfp_pkg::SFP_HOLD: begin
          if (timer == 24'h000000) begin
            o_wip <= 1'b0;
            state <= sfp_pkg::SFP_IDLE;
          end
        end
        default: state <= sfp_pkg::SFP_IDLE;
      endcase
    end
  end

  // checking helpers: last read data and measured busy length
  logic [7:0]  rdata_q;
  logic [23:0] wip_len;
  logic [23:0] exp_len;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rdata_q <= 8'h00;
      wip_len <= 24'h000000;
      exp_len <= 24'h000000;
    end else begin
      rdata_q <= i_arr_rdata;
      if (start && !o_wip) begin
        wip_len <= 24'h000000;
        exp_len <= go_pp ? 24'(PP_CYCLES) : (go_pe ? 24'(PE_CYCLES) : 24'(SSE_CYCLES));
      end else if (o_wip) begin
        wip_len <= wip_len + 24'h000001;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_prog_clears;
    o_arr.wr && kind == sfp_pkg::SFP_K_PROG |-> (o_arr.data & ~rdata_q) == 8'h00;
  endproperty
  a_prog_clears: assert property (p_prog_clears) else $error("program set a bit");

  property p_need_wel;
    $rose(o_wip) |-> $past(o_wel);
  endproperty
  a_need_wel: assert property (p_need_wel) else $error("cycle without latch");

  property p_wrap;
    o_arr.wr && kind == sfp_pkg::SFP_K_PROG |-> o_arr.addr[18:8] == base[18:8];
  endproperty
  a_wrap: assert property (p_wrap) else $error("program left its page");

  property p_wip_len;
    // a reset abort also drops the flag but is not a finished cycle
    $fell(o_wip) && $past(i_resetn) |-> wip_len == exp_len;
  endproperty
  a_wip_len: assert property (p_wip_len) else $error("cycle length wrong");

  property p_wel_clear;
    $fell(o_wip) |-> !o_wel;
  endproperty
  a_wel_clear: assert property (p_wel_clear) else $error("latch still set");

  property p_hw_prot;
    sel_rise && hw_page && (opcode == OP_PP || opcode == OP_PE) |=> !$rose(o_wip);
  endproperty
  a_hw_prot: assert property (p_hw_prot) else $error("protected page altered");

  property p_busy_hold;
    o_wip && !(state == sfp_pkg::SFP_HOLD && timer == 24'h000000)
      |=> o_wip && $stable(kind) && $stable(base);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("running cycle disturbed");

  property p_lock_wel;
    go_lock |=> !o_wel ##1 !o_wip;
  endproperty
  a_lock_wel: assert property (p_lock_wel) else $error("lock write left latch");

  property p_erase_ff;
    o_arr.wr && kind != sfp_pkg::SFP_K_PROG |-> o_arr.data == `SFP_ERASED_BYTE;
  endproperty
  a_erase_ff: assert property (p_erase_ff) else $error("erase wrote non ones");

  property p_erase_frame;
    sel_rise && !o_wip && opcode == OP_PE && byte_cnt != `SFP_HDR_BYTES |=> !o_wip;
  endproperty
  a_erase_frame: assert property (p_erase_frame) else $error("bad erase framing ran");

  property p_wlock;
    sel_rise && wlock |=> !$rose(o_wip);
  endproperty
  a_wlock: assert property (p_wlock) else $error("locked sector altered");

  property p_lockdown;
    // reset is the one legal way to clear lock down
    $past(i_resetn) |-> ($past(down_vec) & ~down_vec) == 8'h00;
  endproperty
  a_lockdown: assert property (p_lockdown) else $error("lock down cleared");

  c_prog: cover property (go_pp ##[1:1000] o_arr.wr);
  c_pe: cover property (go_pe);
  c_sse: cover property (go_sse);
  c_lock: cover property (go_lock ##1 down_vec != 8'h00);

endmodule

// ==== sfp_host_model.sv ====
// spi host model that drives select, serial clock and data into the sequencer
`timescale 1ns/1ps
module sfp_host_model (
  // clock
  input  wire logic         i_clk,
  // serial pins
  output sfp_pkg::sfp_spi_s o_spi
);
  // sck stands low between frames, data shows the inverse of its last bit
  initial o_spi = '{sel_n: 1'b1, sck: 1'b0, din: 1'b0};

  // one frame: select low throughout, msb first, xb stray bits of ones after the bytes
  task automatic frame(input logic [7:0] q[$], input int xb);
    logic b;
    b = 1'b0;
    repeat (2) @(negedge i_clk);
    o_spi.sel_n <= 1'b0;
    for (int i = 0; i < q.size() * 8 + xb; i++) begin
      b = (i < q.size() * 8) ? q[i / 8][7 - i % 8] : 1'b1;
      @(negedge i_clk);
      o_spi.din <= b;
      repeat (2) @(negedge i_clk);
      o_spi.sck <= 1'b1;
      @(negedge i_clk);
      o_spi.sck <= 1'b0;
    end
    @(negedge i_clk);
    o_spi.din   <= ~b;
    o_spi.sel_n <= 1'b1;
  endtask
endmodule

// ==== testbench.sv ====
// self-checking bench for the flash program, erase and lock sequencer
`timescale 1ns/1ps
module testbench;
  // shortened cycle counts keep the run brief
  localparam int         PPC    = 800;
  localparam int         PEC    = 400;
  localparam int         SSC    = 4200;
  localparam logic [7:0] K_WRITE_ENABLE_CMD = 8'h31;
  localparam logic [7:0] K_PP   = 8'h32;
  localparam logic [7:0] K_LOCK = 8'h33;
  localparam logic [7:0] K_PE   = 8'h34;
  localparam logic [7:0] K_SSE  = 8'h35;
  logic              i_clk;
  logic              i_resetn;
  logic              i_hw_prot_en;
  logic [10:0]       i_hw_prot_page;
  logic [7:0]        i_arr_rdata;
  sfp_pkg::sfp_spi_s spi;
  sfp_pkg::sfp_arr_s o_arr;
  logic              o_wip;
  logic              o_wel;
  logic [7:0]        mem [0:524287];
  int                n_fail;
  int                checked;
  int                n;

  sfp_host_model host (.i_clk(i_clk), .o_spi(spi));

  sfp_flash_seq #(
    .OP_WRITE_ENABLE_CMD(K_WRITE_ENABLE_CMD), .OP_PP(K_PP), .OP_LOCK(K_LOCK), .OP_PE(K_PE), .OP_SSE(K_SSE),
    .PP_CYCLES(PPC), .PE_CYCLES(PEC), .SSE_CYCLES(SSC)
  ) uut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_spi(spi), .i_hw_prot_en(i_hw_prot_en),
    .i_hw_prot_page(i_hw_prot_page), .i_arr_rdata(i_arr_rdata), .o_arr(o_arr),
    .o_wip(o_wip), .o_wel(o_wel)
  );

  // array model: read data lands the cycle after the read pulse
  always @(posedge i_clk) begin
    if (o_arr.rd) i_arr_rdata <= mem[o_arr.addr];
    if (o_arr.wr) mem[o_arr.addr] <= o_arr.data;
  end

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // counts busy cycles; bounded so a stuck flag cannot hang the run
  task automatic busy(output int c);
    c = 0;
    @(negedge i_clk);
    while (o_wip === 1'b1) begin
      c++;
      if (c > 20000) begin
        n_fail++;
        print_verdict();
      end
      @(negedge i_clk);
    end
  endtask

  // data byte k of a frame; bytes past 256 differ from their wrapped twins
  function automatic logic [7:0] pat(input logic [7:0] d, input int k);
    return (d + k[7:0]) ^ {k[8], 7'h0};
  endfunction

  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int nd,
                     input logic [7:0] d0, input int xb, output int c);
    logic [7:0] q[$];
    q = '{op, a[23:16], a[15:8], a[7:0]};
    for (int k = 0; k < nd; k++) q.push_back(pat(d0, k));
    host.frame(q, xb);
    busy(c);
  endtask

  task automatic we();
    int c;
    host.frame('{K_WRITE_ENABLE_CMD}, 0);
    busy(c);
    chk("wel set", 32'h1, o_wel);
  endtask

  // program: and-ing, top bits ignored, wrap, timing
  task automatic s_prog();
    cmd(K_PP, 24'h000010, 1, 8'h00, 0, n);
    chk("pp no wel", 32'h0, n);
    mem[19'h001fe] = 8'hf0;
    we();
    cmd(K_PP, 24'hf801fe, 3, 8'h3c, 0, n);
    chk("pp time", PPC, n);
    chk("pp wel", 32'h0, o_wel);
    chk("pp and", 32'h30, mem[19'h001fe]);
    chk("pp wrap", 32'h3e, mem[19'h00100]);
    chk("pp next", 32'hff, mem[19'h00200]);
  endtask

  // framing errors, long program, page erase
  task automatic s_frame_pe();
    we();
    cmd(K_PP, 24'h000300, 1, 8'h00, 3, n);
    chk("pp frame", 32'hff, mem[19'h00300]);
    cmd(K_PE, 24'h000300, 1, 8'h00, 0, n);
    chk("pe frame", 32'h0, n);
    cmd(K_PP, 24'h000400, 258, 8'h00, 0, n); // 258 bytes, two more than a whole page, in one sequence
    chk("pp last 256", 32'h81, mem[19'h00401]);
    chk("pp mid", 32'h02, mem[19'h00402]);
    mem[19'h00500] = 8'h00;
    we();
    cmd(K_PE, 24'h000433, 0, 8'h00, 0, n);
    chk("pe time", PEC, n);
    chk("pe low", 32'hff, mem[19'h00400]);
    chk("pe high", 32'hff, mem[19'h004ff]);
    chk("pe next", 32'h00, mem[19'h00500]);
  endtask

  // lock byte: write lock, lock down, hardware protection
  task automatic s_lock();
    we();
    cmd(K_LOCK, 24'h020000, 1, 8'h01, 0, n);
    chk("lock untimed", 32'h0, n);
    chk("lock wel", 32'h0, o_wel);
    we();
    cmd(K_PP, 24'h020010, 1, 8'h00, 0, n);
    chk("locked pp", 32'h0, n);
    cmd(K_SSE, 24'h021000, 0, 8'h00, 0, n);
    chk("locked sse", 32'h0, n);
    cmd(K_LOCK, 24'h020000, 1, 8'h03, 0, n);
    we();
    cmd(K_LOCK, 24'h020000, 1, 8'h00, 0, n);
    we();
    cmd(K_PP, 24'h020010, 1, 8'h00, 0, n);
    chk("lock down", 32'h0, n);
    i_hw_prot_page = 11'h010;
    i_hw_prot_en   = 1'b1;
    cmd(K_PP, 24'h001000, 1, 8'h00, 0, n);
    chk("hw pp", 32'h0, n);
    cmd(K_PE, 24'h001000, 0, 8'h00, 0, n);
    chk("hw pe", 32'h0, n);
    i_hw_prot_en = 1'b0;
  endtask

  // subsector erase, refusal while busy, reset abort
  task automatic s_sse();
    mem[19'h03000] = 8'h00;
    mem[19'h04000] = 8'h00;
    cmd(K_SSE, 24'h003456, 0, 8'h00, 0, n);
    chk("sse time", SSC, n);
    chk("sse erased", 32'hff, mem[19'h03000]);
    chk("sse next", 32'h00, mem[19'h04000]);
    we();
    host.frame('{K_SSE, 8'h00, 8'h50, 8'h00}, 0);
    host.frame('{K_WRITE_ENABLE_CMD}, 0);
    cmd(K_PP, 24'h000600, 1, 8'h00, 0, n);
    chk("busy kept", 32'h1, n > 0);
    chk("busy wel", 32'h0, o_wel);
    chk("busy pp", 32'hff, mem[19'h00600]);
    we();
    host.frame('{K_SSE, 8'h00, 8'h70, 8'h00}, 0);
    repeat (100) @(negedge i_clk);
    i_resetn = 1'b0;
    @(negedge i_clk);
    chk("abort wip", 32'h0, o_wip);
    chk("abort wel", 32'h0, o_wel);
    i_resetn = 1'b1;
    we();
    cmd(K_PP, 24'h020010, 1, 8'h00, 0, n);
    chk("lock reset", PPC, n);
  endtask

  initial begin
    n_fail         = 0;
    checked        = 0;
    i_resetn       = 1'b0;
    i_hw_prot_en   = 1'b0;
    i_hw_prot_page = 11'h000;
    i_arr_rdata    = 8'h00;
    foreach (mem[i]) mem[i] = 8'hff;
    repeat (8) @(negedge i_clk);
    i_resetn = 1'b1;
    chk("reset wip", 32'h0, o_wip);
    chk("reset wel", 32'h0, o_wel);
    s_prog();
    s_frame_pe();
    s_lock();
    s_sse();
    print_verdict();
  end
endmodule
